// ==== dpdc_divider.sv ====
// Low/high phase clock divider with edge select and bypass
`default_nettype none
module dpdc_divider (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_srst,
   // Applied setting
   input wire dpdc_pkg::dpdc_div_cfg_t i_cfg,
   // Counting clock, already synchronised
   input wire logic i_src_level,
   input wire logic i_src_rise,
   input wire logic i_src_fall,
   // Divided clock
   output logic o_div
);
   import dpdc_pkg::*;

   logic high_reg, high_next;
   logic [5:0] cnt_reg, cnt_next;
   logic out_reg, out_next;

   // A zero phase length behaves as one source cycle
   wire [5:0] low_len = (i_cfg.low_phase_count == 6'h00) ?
      6'h01 : i_cfg.low_phase_count;
   wire [6:0] high_len = (i_cfg.high_phase_count == 6'h00) ?
      7'h01 : {1'b0, i_cfg.high_phase_count};
   // High phase steps on the selected source edge
   wire high_evt = i_cfg.edge_sel ? i_src_fall : i_src_rise;
   // Falling-edge high phase ends half a cycle late; low gives it back
   wire [6:0] high_end = high_len + {6'h00, i_cfg.edge_sel};
   wire step = high_reg ? high_evt : i_src_rise;
   wire [6:0] cnt_inc = {1'b0, cnt_reg} + 7'h01;
   wire [6:0] len = high_reg ? high_end : {1'b0, low_len};
   wire wrap = step && (cnt_inc >= len);

   // Phase and count update; ratio is low length plus high length
   assign high_next = wrap ? ~high_reg : high_reg;
   assign cnt_next = wrap ? 6'h00 : (step ? cnt_inc[5:0] : cnt_reg);
   // Bypass passes the counting clock straight through
   assign out_next = i_cfg.bypass ? i_src_level : high_next;

   // Divider state
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         high_reg <= 1'b0;
         cnt_reg <= 6'h00;
         out_reg <= 1'b0;
      end else begin
         high_reg <= high_next;
         cnt_reg <= cnt_next;
         out_reg <= out_next;
      end
   end

   assign o_div = out_reg;
endmodule
`default_nettype wire

// ==== dpdc_pkg.sv ====
// Shared constants and types for the dual PLL divider control block
`default_nettype none
package dpdc_pkg;
   // ------------------------------------------------------------------
   // Register port widths
   // ------------------------------------------------------------------
   localparam int ADDR_W = 13;
   localparam int DATA_W = 32;
   localparam int CFG_W = 15;
   localparam int NUM_PLL = 2;
   localparam int NUM_DIV = 3;

   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [12:0] OFS_TUN_IN = 13'h0040;
   localparam logic [12:0] OFS_TUN_FB = 13'h0044;
   localparam logic [12:0] OFS_TUN_OUT = 13'h0048;
   localparam logic [12:0] OFS_CORE_IN = 13'h0080;
   localparam logic [12:0] OFS_CORE_FB = 13'h0084;
   localparam logic [12:0] OFS_CORE_OUT = 13'h0088;
   localparam logic [12:0] OFS_TUN_LOCK = 13'h0108;
   localparam logic [12:0] OFS_CORE_LOCK = 13'h0110;

   // ------------------------------------------------------------------
   // Reset values of the divider registers (bits 14:0 are stored)
   // ------------------------------------------------------------------
   localparam logic [14:0] RST_IN_DIV = 15'h2041;
   localparam logic [14:0] RST_FB_DIV = 15'h03cf;
   localparam logic [14:0] RST_OUT_DIV = 15'h028a;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int LOW_LSB = 0;
   localparam int HIGH_LSB = 6;
   localparam int EDGE_BIT = 12;
   localparam int BYPASS_BIT = 13;
   localparam int INHIBIT_BIT = 14;
   localparam int LOCK_BIT = 0;
   localparam int ERROR_BIT = 1;

   // ------------------------------------------------------------------
   // Frequency plan and timing
   // ------------------------------------------------------------------
   localparam logic [17:0] REF_MHZ = 18'h00021;
   localparam logic [17:0] VCO_MIN_MHZ = 18'h00258;
   localparam logic [17:0] VCO_MAX_MHZ = 18'h005a0;
   localparam int CLK_PERIOD_NS = 20;
   localparam int LOCK_SETTLE_NS = 2000;
   localparam int LOCK_SETTLE_CYC =
      (LOCK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] SETTLE_LAST = 8'(LOCK_SETTLE_CYC - 1);

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic apply_inhibit;
      logic bypass;
      logic edge_sel;
      logic [5:0] high_phase_count;
      logic [5:0] low_phase_count;
   } dpdc_div_cfg_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [12:0] addr;
      logic [31:0] wdata;
   } dpdc_reg_req_t;

   typedef enum logic [1:0] {
      DPDC_DIV_IN = 2'h0,
      DPDC_DIV_FB = 2'h1,
      DPDC_DIV_OUT = 2'h2
   } dpdc_div_kind_t;

   typedef enum logic [2:0] {
      DPDC_LK_LOCKED = 3'h1,
      DPDC_LK_SETTLE = 3'h2,
      DPDC_LK_WAIT = 3'h4
   } dpdc_lock_state_t;
endpackage
`default_nettype wire

// ==== dpdc_sync3.sv ====
// Three-stage pin synchroniser with debounced level and edge pulses
`default_nettype none
module dpdc_sync3 (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_srst,
   // Asynchronous pin
   input wire logic i_pin,
   // Synchronised level and edges
   output logic o_level,
   output logic o_rise,
   output logic o_fall
);
   import dpdc_pkg::*;

   logic s1_reg, s2_reg, s3_reg;
   logic level_reg, rise_reg, fall_reg;
   wire agree = (s2_reg == s3_reg);

   // Shift chain; a change counts once stages two and three agree
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         level_reg <= 1'b0;
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
      end else begin
         s1_reg <= i_pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level_reg <= agree ? s3_reg : level_reg;
         rise_reg <= agree && s3_reg && !level_reg;
         fall_reg <= agree && !s3_reg && level_reg;
      end
   end

   assign o_level = level_reg;
   assign o_rise = rise_reg;
   assign o_fall = fall_reg;
endmodule
`default_nettype wire

// ==== dpdc_top.sv ====
// Register file, dividers and lock/error status for two PLLs
`default_nettype none
// Operation
// - The input divider holds its output low for the low count and high for the high count of reference cycles.
// - The feedback divider counts oscillator cycles low then high, its ratio being the sum of both counts.
// - The oscillator frequency is the 33 MHz reference over the input ratio times the feedback ratio.
// - The output divider divides the oscillator clock by the sum of its own low and high counts.
// - Bit 12 makes the high phase step on the rising edge when clear and on the falling edge when set.
// - Bit 13 makes a divider pass its counting clock through undivided.
// - Bit 14 keeps a written value readable but stops it from reaching the PLL.
// - Each PLL has a read-only status whose bit 0 is one while locked and zero while unlocked.
// - Status bit 1 is high after an illegal setting, and software waits for it to clear before reprogramming.
// - The tunnel PLL output divider makes the tunnel clock and the core PLL one makes the core clock.
module dpdc_top (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_srst,
   // Register port
   input wire dpdc_pkg::dpdc_reg_req_t i_reg,
   output logic [31:0] o_reg_rdata,
   output logic o_reg_ack,
   // Analogue PLL pins, index 0 tunnel, index 1 core
   input wire logic i_ref_clk,
   input wire logic [1:0] i_vco_clk,
   input wire logic [1:0] i_pll_lock,
   // Divided clocks to the analogue PLLs
   output logic [1:0] o_ref_div,
   output logic [1:0] o_fb_div,
   // Generated clocks
   output logic o_tunnel_clk,
   output logic o_core_clk
);
   import dpdc_pkg::*;

   // ------------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------------

   // Divider register decode: {hit, pll, kind}
   function automatic logic [3:0] dpdc_decode(input logic [12:0] a);
      logic [3:0] r;
      r = 4'h0;
      case (a)
         OFS_TUN_IN: r = {1'b1, 1'b0, DPDC_DIV_IN};
         OFS_TUN_FB: r = {1'b1, 1'b0, DPDC_DIV_FB};
         OFS_TUN_OUT: r = {1'b1, 1'b0, DPDC_DIV_OUT};
         OFS_CORE_IN: r = {1'b1, 1'b1, DPDC_DIV_IN};
         OFS_CORE_FB: r = {1'b1, 1'b1, DPDC_DIV_FB};
         OFS_CORE_OUT: r = {1'b1, 1'b1, DPDC_DIV_OUT};
         default: r = 4'h0;
      endcase
      return r;
   endfunction

   // Effective ratio of one divider, one when bypassed
   function automatic logic [17:0] dpdc_ratio(input dpdc_div_cfg_t c);
      logic [6:0] s;
      s = {1'b0, c.low_phase_count} + {1'b0, c.high_phase_count};
      return c.bypass ? 18'h00001 : {11'h000, s};
   endfunction

   // A setting is illegal with an empty phase or the VCO out of range
   function automatic logic dpdc_illegal(input dpdc_div_cfg_t ci,
                                         input dpdc_div_cfg_t cf,
                                         input dpdc_div_cfg_t co);
      logic empty;
      logic [17:0] ri, rf, vco_x, lo, hi;
      empty = 1'b0;
      if (!ci.bypass && (ci.low_phase_count == 6'h00 ||
                         ci.high_phase_count == 6'h00))
         empty = 1'b1;
      if (!cf.bypass && (cf.low_phase_count == 6'h00 ||
                         cf.high_phase_count == 6'h00))
         empty = 1'b1;
      if (!co.bypass && (co.low_phase_count == 6'h00 ||
                         co.high_phase_count == 6'h00))
         empty = 1'b1;
      ri = dpdc_ratio(ci);
      rf = dpdc_ratio(cf);
      vco_x = 18'(REF_MHZ * rf);
      lo = 18'(VCO_MIN_MHZ * ri);
      hi = 18'(VCO_MAX_MHZ * ri);
      return empty || (vco_x < lo) || (vco_x > hi);
   endfunction

   // ------------------------------------------------------------------
   // Register port decode
   // ------------------------------------------------------------------

   // Address decode shared by read and write paths
   wire [3:0] dec = dpdc_decode(i_reg.addr);
   wire dec_hit = dec[3];
   wire dec_pll = dec[2];
   wire [1:0] dec_kind = dec[1:0];
   wire stat_tun = (i_reg.addr == OFS_TUN_LOCK);
   wire stat_core = (i_reg.addr == OFS_CORE_LOCK);
   wire [14:0] wr_val = i_reg.wdata[14:0];
   wire wr_cfg = i_reg.wr && dec_hit;
   // Apply only when the written value does not inhibit it
   wire wr_apply = wr_cfg && !wr_val[INHIBIT_BIT];

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   dpdc_div_cfg_t cfg_reg [NUM_PLL][NUM_DIV];
   dpdc_div_cfg_t cfg_next [NUM_PLL][NUM_DIV];
   dpdc_div_cfg_t act_reg [NUM_PLL][NUM_DIV];
   dpdc_div_cfg_t act_next [NUM_PLL][NUM_DIV];
   dpdc_div_cfg_t cand [NUM_PLL][NUM_DIV];
   logic [1:0] apply_p;
   logic [1:0] bad_p;
   logic [1:0] lock_bit;
   logic [1:0] err_bit;
   logic [1:0] out_clk;
   logic [31:0] rdata_reg, rdata_next;
   logic ack_reg;

   // Synchronised reference clock, shared by both input dividers
   logic ref_lvl, ref_rise, ref_fall;
   dpdc_sync3 u_ref_sync (
      .i_mclk (i_mclk),
      .i_srst (i_srst),
      .i_pin (i_ref_clk),
      .o_level (ref_lvl),
      .o_rise (ref_rise),
      .o_fall (ref_fall)
   );

   // ------------------------------------------------------------------
   // Per-PLL logic
   // ------------------------------------------------------------------
   genvar p, k;
   generate
      for (p = 0; p < NUM_PLL; p++) begin : g_pll
         logic vco_lvl, vco_rise, vco_fall;
         logic lock_lvl, lock_fall;
         dpdc_lock_state_t st_reg, st_next;
         logic [7:0] cnt_reg, cnt_next;
         logic err_reg, err_next;
         wire settle_done;

         // Divider register write and apply, per kind
         for (k = 0; k < NUM_DIV; k++) begin : g_div
            wire this_wr = wr_cfg && (dec_pll == 1'(p)) &&
               (dec_kind == 2'(k));
            // Written value is held whether or not it is applied
            assign cfg_next[p][k] = this_wr ? dpdc_div_cfg_t'(wr_val) :
               cfg_reg[p][k];
            assign cand[p][k] = this_wr ? dpdc_div_cfg_t'(wr_val) :
               act_reg[p][k];
            // Only a legal apply changes what the PLL runs on
            assign act_next[p][k] = (apply_p[p] && !bad_p[p]) ?
               cand[p][k] : act_reg[p][k];
            always_ff @(posedge i_mclk) begin
               if (i_srst) begin
                  cfg_reg[p][k] <= dpdc_div_cfg_t'((k == 0) ? RST_IN_DIV :
                     (k == 1) ? RST_FB_DIV : RST_OUT_DIV);
                  act_reg[p][k] <= dpdc_div_cfg_t'((k == 0) ? RST_IN_DIV :
                     (k == 1) ? RST_FB_DIV : RST_OUT_DIV);
               end else begin
                  cfg_reg[p][k] <= cfg_next[p][k];
                  act_reg[p][k] <= act_next[p][k];
               end
            end
         end

         // Apply request and legality of the setting it would produce
         assign apply_p[p] = wr_apply && (dec_pll == 1'(p));
         assign bad_p[p] = dpdc_illegal(cand[p][0], cand[p][1],
                                        cand[p][2]);

         // Oscillator and lock pins from the analogue PLL
         dpdc_sync3 u_vco_sync (
            .i_mclk (i_mclk),
            .i_srst (i_srst),
            .i_pin (i_vco_clk[p]),
            .o_level (vco_lvl),
            .o_rise (vco_rise),
            .o_fall (vco_fall)
         );
         dpdc_sync3 u_lock_sync (
            .i_mclk (i_mclk),
            .i_srst (i_srst),
            .i_pin (i_pll_lock[p]),
            .o_level (lock_lvl),
            .o_rise (),
            .o_fall (lock_fall)
         );

         // Input divider counts reference cycles
         dpdc_divider u_in_div (
            .i_mclk (i_mclk),
            .i_srst (i_srst),
            .i_cfg (act_reg[p][0]),
            .i_src_level (ref_lvl),
            .i_src_rise (ref_rise),
            .i_src_fall (ref_fall),
            .o_div (o_ref_div[p])
         );

         // Feedback divider counts oscillator cycles
         dpdc_divider u_fb_div (
            .i_mclk (i_mclk),
            .i_srst (i_srst),
            .i_cfg (act_reg[p][1]),
            .i_src_level (vco_lvl),
            .i_src_rise (vco_rise),
            .i_src_fall (vco_fall),
            .o_div (o_fb_div[p])
         );

         // Output divider makes the PLL's delivered clock
         dpdc_divider u_out_div (
            .i_mclk (i_mclk),
            .i_srst (i_srst),
            .i_cfg (act_reg[p][2]),
            .i_src_level (vco_lvl),
            .i_src_rise (vco_rise),
            .i_src_fall (vco_fall),
            .o_div (out_clk[p])
         );

         // Lock tracking after an apply
         assign settle_done = (st_reg == DPDC_LK_SETTLE) &&
            (cnt_reg == SETTLE_LAST);
         always_comb begin
            st_next = st_reg;
            cnt_next = 8'h00;
            if (apply_p[p]) begin
               st_next = DPDC_LK_SETTLE;
            end else begin
               case (st_reg)
                  DPDC_LK_LOCKED: begin
                     // A seen fall only: the reset low of the sync is no loss
                     if (lock_fall)
                        st_next = DPDC_LK_WAIT;
                  end
                  DPDC_LK_SETTLE: begin
                     cnt_next = cnt_reg + 8'h01;
                     if (settle_done)
                        st_next = DPDC_LK_WAIT;
                  end
                  DPDC_LK_WAIT: begin
                     if (lock_lvl)
                        st_next = DPDC_LK_LOCKED;
                  end
                  default: st_next = DPDC_LK_WAIT;
               endcase
            end
         end

         // Error sets on an illegal apply and clears once settled
         assign err_next = (apply_p[p] && bad_p[p]) ? 1'b1 :
            (settle_done ? 1'b0 : err_reg);

         always_ff @(posedge i_mclk) begin
            if (i_srst) begin
               st_reg <= DPDC_LK_LOCKED;
               cnt_reg <= 8'h00;
               err_reg <= 1'b0;
            end else begin
               st_reg <= st_next;
               cnt_reg <= cnt_next;
               err_reg <= err_next;
            end
         end

         assign lock_bit[p] = (st_reg == DPDC_LK_LOCKED);
         assign err_bit[p] = err_reg;
      end
   endgenerate

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------

   // Stored divider value, reserved bits read zero
   wire [14:0] rd_cfg = cfg_reg[dec_pll][dec_kind];
   wire [31:0] stat_tun_w = {30'h0, err_bit[0], lock_bit[0]};
   wire [31:0] stat_core_w = {30'h0, err_bit[1], lock_bit[1]};

   // Read data select; unmapped addresses read zero
   assign rdata_next = !i_reg.rd ? rdata_reg :
      dec_hit ? {17'h00000, rd_cfg} :
      stat_tun ? stat_tun_w :
      stat_core ? stat_core_w :
      32'h00000000;

   // Read data and access acknowledge
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         rdata_reg <= 32'h00000000;
         ack_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         ack_reg <= i_reg.rd || i_reg.wr;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign o_reg_rdata = rdata_reg;
   assign o_reg_ack = ack_reg;
   assign o_tunnel_clk = out_clk[0];
   assign o_core_clk = out_clk[1];
endmodule
`default_nettype wire

// ==== dpdc_top_checker.sv ====
// Concurrent checks on the register port of the PLL divider block
`default_nettype none
module dpdc_top_checker (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_srst,
   // Register port
   input wire dpdc_pkg::dpdc_reg_req_t i_reg,
   input wire logic [31:0] o_reg_rdata,
   input wire logic o_reg_ack
);
   import dpdc_pkg::*;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   wire logic req_any = i_reg.wr | i_reg.rd;
   wire logic core_div = i_reg.addr inside {OFS_CORE_IN, OFS_CORE_FB,
      OFS_CORE_OUT};
   wire logic stat = i_reg.addr inside {OFS_TUN_LOCK, OFS_CORE_LOCK};
   wire logic mapped = core_div | stat |
      (i_reg.addr inside {OFS_TUN_IN, OFS_TUN_FB, OFS_TUN_OUT});

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_srst);

   // Applying write to the core PLL, then a read of its status
   sequence seq_apply;
      i_reg.wr && core_div && !i_reg.wdata[14];
   endsequence
   sequence seq_lock_rd;
      i_reg.rd && i_reg.addr == OFS_CORE_LOCK;
   endsequence

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   chk_ack_after_req: assert property (req_any |=> o_reg_ack)
      else $error("ack missing after request");
   chk_ack_has_cause: assert property (o_reg_ack |-> $past(req_any))
      else $error("ack without request");
   chk_ack_one_cycle: assert property (o_reg_ack && !req_any |=> !o_reg_ack)
      else $error("ack longer than one cycle");
   chk_rdata_hold: assert property (!i_reg.rd |=> $stable(o_reg_rdata))
      else $error("read data moved without a read");
   chk_unmapped_zero: assert property (
      i_reg.rd && !mapped |=> o_reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   chk_upper_bits_zero: assert property (
      o_reg_ack |-> o_reg_rdata[31:15] == 17'h0)
      else $error("unused read bits set");
   chk_status_reserved: assert property (
      i_reg.rd && stat |=> o_reg_rdata[31:2] == 30'h0)
      else $error("status reserved bits set");
   chk_apply_unlocks: assert property (
      seq_apply ##[1:4] seq_lock_rd |=> o_reg_rdata[0] == 1'b0)
      else $error("lock still shown after apply");
endmodule

bind dpdc_top dpdc_top_checker dpdc_top_checker_i (
   .i_mclk(i_mclk),
   .i_srst(i_srst),
   .i_reg(i_reg),
   .o_reg_rdata(o_reg_rdata),
   .o_reg_ack(o_reg_ack)
);
`default_nettype wire

// ==== dpdc_top_tb.sv ====
// Self-checking bench for the dual PLL divider control block
`default_nettype none
`define CMP(nm, e, g) cmp_vals(nm, 32'(e), 32'(g))
module dpdc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dpdc_pkg::*;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic i_mclk = 1'b0;
   logic i_srst = 1'b1;
   dpdc_reg_req_t req = '0;
   logic ref_clk = 1'b0;
   logic [1:0] vco = 2'b00;
   logic [1:0] lock_pin = 2'b11;
   wire logic [31:0] rdata;
   wire logic ack;
   wire logic [1:0] ref_div;
   wire logic [1:0] fb_div;
   wire logic tun_clk;
   wire logic core_clk;
   int err_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int hi;
   int lo;
   int k;
   logic [31:0] d;
   logic [63:0] nt;
   logic [63:0] exp_q[$];
   logic [12:0] offs[9] = '{OFS_TUN_IN, OFS_TUN_FB, OFS_TUN_OUT,
      OFS_CORE_IN, OFS_CORE_FB, OFS_CORE_OUT, OFS_TUN_LOCK,
      OFS_CORE_LOCK, 13'h000c};
   logic [31:0] rvals[9] = '{32'h2041, 32'h03cf, 32'h028a, 32'h2041,
      32'h03cf, 32'h028a, 32'h1, 32'h1, 32'h0};
   int mexp[6] = '{8, 80, 80, 120, 8, 120};

   // Clocks: system, slow reference, slow oscillators
   always #10 i_mclk = ~i_mclk;
   always #160 ref_clk = ~ref_clk;
   always #80 vco = ~vco;

   dpdc_top dpdc_top_i (
      .i_mclk(i_mclk),
      .i_srst(i_srst),
      .i_reg(req),
      .o_reg_rdata(rdata),
      .o_reg_ack(ack),
      .i_ref_clk(ref_clk),
      .i_vco_clk(vco),
      .i_pll_lock(lock_pin),
      .o_ref_div(ref_div),
      .o_fb_div(fb_div),
      .o_tunnel_clk(tun_clk),
      .o_core_clk(core_clk)
   );

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic cmp_vals(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tally_and_finish();
      if (err_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // One register access; a read notes its masked expected word
   task automatic acc(input logic w, input logic [12:0] a,
      input logic [31:0] dv, input logic [31:0] m);
      @(posedge i_mclk);
      #1;
      req.wr = w;
      req.rd = ~w;
      req.addr = a;
      req.wdata = w ? dv : 32'h0;
      exp_q.push_back({m, dv & m});
      @(posedge i_mclk);
      #1;
      req.wr = 1'b0;
      req.rd = 1'b0;
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return ref_div[1];
         1: return core_clk;
         2: return tun_clk;
         3: return fb_div[1];
         4: return ref_div[0];
         default: return fb_div[0];
      endcase
   endfunction

   // Count cycles while a divided clock keeps one level
   task automatic hold(input int s, input logic v, output int n);
      n = 0;
      while (pick(s) === v && n < 4000) begin
         @(posedge i_mclk);
         #1;
         n++;
      end
   endtask

   task automatic meas(input int s, output int h, output int l);
      int n;
      hold(s, 1'b1, n);
      hold(s, 1'b0, n);
      hold(s, 1'b1, h);
      hold(s, 1'b0, l);
   endtask

   // Read answers are compared against the oldest note
   always @(posedge i_mclk) begin
      if (ack === 1'b1) begin
         if (exp_q.size() == 0) begin
            `CMP("spurious ack", 0, 1);
         end else begin
            nt = exp_q.pop_front();
            `CMP("read data", nt[31:0], rdata & nt[63:32]);
         end
      end
   end

   // Hang guard
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      d = $urandom(32'h2a56);
      repeat (5) @(posedge i_mclk);
      #1;
      i_srst = 1'b0;
      // Reset values, an unmapped place and a read-only status
      foreach (offs[j]) acc(1'b0, offs[j], rvals[j], 32'hffffffff);
      acc(1'b1, 13'h000c, 32'h5, 32'h0);
      acc(1'b0, 13'h000c, 32'h0, 32'hffffffff);
      acc(1'b1, OFS_CORE_LOCK, 32'h0, 32'h0);
      acc(1'b0, OFS_CORE_LOCK, 32'h1, 32'hffffffff);
      // Reset settings of every divider of both PLLs
      foreach (mexp[j]) begin
         meas(j, hi, lo);
         `CMP("high phase", mexp[j], hi);
         `CMP("low phase", mexp[j], lo);
      end
      // Legal feedback then input setting, relock afterwards
      acc(1'b1, OFS_CORE_FB, 32'h0514, 32'h0);
      acc(1'b0, OFS_CORE_LOCK, 32'h0, 32'h1);
      acc(1'b1, OFS_CORE_IN, 32'h0041, 32'h0);
      repeat (120) @(posedge i_mclk);
      acc(1'b0, OFS_CORE_LOCK, 32'h1, 32'h3);
      meas(0, hi, lo);
      `CMP("input div", 32, hi + lo);
      meas(3, hi, lo);
      `CMP("fb high", 160, hi);
      `CMP("fb low", 160, lo);
      // Input ratio that takes the oscillator out of range
      acc(1'b1, OFS_CORE_IN, 32'h0082, 32'h0);
      repeat (4) @(posedge i_mclk);
      acc(1'b0, OFS_CORE_LOCK, 32'h2, 32'h2);
      meas(0, hi, lo);
      `CMP("kept input div", 16, hi);
      repeat (120) @(posedge i_mclk);
      acc(1'b0, OFS_CORE_LOCK, 32'h0, 32'h2);
      // Odd output ratio with falling-edge high phase
      acc(1'b1, OFS_CORE_OUT, 32'h1042, 32'h0);
      meas(1, hi, lo);
      `CMP("odd period", 24, hi + lo);
      repeat (120) @(posedge i_mclk);
      // Inhibited writes are stored but never applied
      repeat (4) begin
         k = $urandom_range(5, 0);
         d = {17'h0, 1'b1, 14'($urandom)};
         acc(1'b1, offs[k], d, 32'h0);
         acc(1'b0, offs[k], d, 32'hffffffff);
      end
      acc(1'b0, OFS_CORE_LOCK, 32'h1, 32'h1);
      // Tunnel lock pin drops
      lock_pin[0] = 1'b0;
      repeat (8) @(posedge i_mclk);
      acc(1'b0, OFS_TUN_LOCK, 32'h0, 32'h1);
      repeat (3) @(posedge i_mclk);
      tally_and_finish();
   end
endmodule
`default_nettype wire
